// [pkg/can_mode_pkg.sv]
// Purpose: Shared constants and types for the CAN mode control and filter identifier block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Register offsets are byte addresses
package can_mode_pkg;
	// Register map
	localparam logic [7:0] ctrl_one_off = 8'h00;
	localparam logic [7:0] status_off = 8'h04;
	localparam logic [7:0] rx_id_off = 8'h08;
	localparam logic [7:0] filter_base_off = 8'h40;
	localparam int filter_count = 16;
	// Control one field positions
	localparam int mode_request_lsb = 8;
	localparam int current_mode_lsb = 5;
	localparam int capture_enable_bit = 3;
	localparam int window_select_bit = 0;
	// Filter identifier field positions
	localparam int filter_sid_lsb = 5;
	localparam int extended_enable_bit = 3;
	localparam int extended_upper_lsb = 0;
	// Reset values
	localparam logic [2:0] mode_request_reset = 3'h4;
	localparam logic [2:0] current_mode_reset = 3'h4;
	localparam logic [15:0] filter_reset = 16'h0000;
	// Cycles a mode change takes to settle
	localparam int mode_settle_cycles = 4;
	// AXI responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef enum logic [2:0] {
		mode_normal = 3'h0,
		mode_disabled = 3'h1,
		mode_loopback = 3'h2,
		mode_listen_only = 3'h3,
		mode_config = 3'h4,
		mode_listen_all = 3'h7
	} op_mode_e;

	// Received frame header from the protocol engine
	typedef struct packed {
		logic valid;
		logic extended;
		logic [10:0] filter_standard_id;
		logic [1:0] eid_upper;
	} rx_header_s;

	// One filter's stored identifier
	typedef struct packed {
		logic [10:0] filter_standard_id;
		logic extended_id_enable;
		logic [1:0] eid_upper;
	} filter_id_s;

	// Legal mode codes only; reserved codes fold to configuration
	function automatic op_mode_e decode_mode(input logic [2:0] code);
		unique case (code)
			3'h0: decode_mode = mode_normal;
			3'h1: decode_mode = mode_disabled;
			3'h2: decode_mode = mode_loopback;
			3'h3: decode_mode = mode_listen_only;
			3'h7: decode_mode = mode_listen_all;
			default: decode_mode = mode_config;
		endcase
	endfunction
endpackage

// [logic/filter_match.sv]
// Purpose: Compare one received header against all sixteen filter identifiers
// Assumes: Headers come from logic on the same clock
// Notes: Masks are outside this block, so every standard identifier bit is compared; upper bits only for extended headers
`timescale 1ns/1ps
module filter_match #(
	parameter int count = 16
) (
	input wire can_mode_pkg::rx_header_s header,
	input wire can_mode_pkg::filter_id_s [count-1:0] filters,
	input wire logic mask_id_type_enable,
	output logic [count-1:0] hit
);
	import can_mode_pkg::*;

	// Exact compare per filter; type checked only when the mask asks for it
	always_comb begin
		for (int i = 0; i < count; i++) begin
			hit[i] = header.valid && (header.filter_standard_id == filters[i].filter_standard_id);
			if (mask_id_type_enable) begin
				hit[i] = hit[i] && (header.extended == filters[i].extended_id_enable);
			end
			if (header.extended) begin
				hit[i] = hit[i] && (header.eid_upper == filters[i].eid_upper);
			end
		end
	end
endmodule

// [logic/can_mode_control.sv]
// Purpose: Mode request and report, capture enable, window select and filter identifier registers
// Assumes: AXI4-Lite slave at 40 MHz, header input from the protocol engine on aclk
// Notes: Mode status changes only after the settle delay completes
// Behaviour
// - Current mode is a read-only three-bit field with listed codes.
// - Codes 101 and 110 are never reported as current mode.
// - Capture enable set gives a capture pulse per received message outside disabled and configuration modes; clear gives none.
// - Stored identifier bits must equal received standard identifier bits to match.
// - Sixteen independent filters, each with identifier, type enable and two upper bits.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module can_mode_control #(
	parameter int filters = can_mode_pkg::filter_count,
	parameter int settle = can_mode_pkg::mode_settle_cycles
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire can_mode_pkg::rx_header_s rx_header,
	input wire logic mask_id_type_enable,
	output can_mode_pkg::op_mode_e current_mode_status,
	output logic window_select,
	output logic capture_event,
	output logic [filters-1:0] filter_hit,
	output logic rx_hit
);
	import can_mode_pkg::*;

	logic [2:0] mode_request_reg;
	op_mode_e current_mode_reg;
	logic receive_capture_enable_reg;
	logic window_reg;
	filter_id_s [filters-1:0] filter_reg;
	logic [2:0] settle_reg;
	logic aw_held_reg, w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [13:0] last_id_reg;
	logic [filters-1:0] hit_now;
	logic do_write;
	logic [31:0] rdata_next;
	op_mode_e requested;
	logic rd_err_next;

	assign requested = decode_mode(mode_request_reg);
	assign current_mode_status = current_mode_reg;
	assign window_select = window_reg;

	// Write channel capture; address and data may arrive in either order
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response; unmapped or read-only targets answer with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_reg == ctrl_one_off ||
				(awaddr_reg >= filter_base_off &&
				awaddr_reg < filter_base_off + 8'(4 * filters))) ? resp_okay : resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control one writes; byte lane 1 carries the request, lane 0 the rest
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_request_reg <= mode_request_reset;
			receive_capture_enable_reg <= 1'b0;
			window_reg <= 1'b0;
		end else if (do_write && awaddr_reg == ctrl_one_off) begin
			if (wstrb_reg[1]) begin
				mode_request_reg <= wdata_reg[mode_request_lsb +: 3];
			end
			if (wstrb_reg[0]) begin
				receive_capture_enable_reg <= wdata_reg[capture_enable_bit];
				window_reg <= wdata_reg[window_select_bit];
			end
		end
	end

	// Filter identifier writes; reserved bits are simply not stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filter_reg <= '0;
		end else if (do_write && awaddr_reg[7:6] == filter_base_off[7:6]) begin
			for (int i = 0; i < filters; i++) begin
				if (awaddr_reg[5:2] == 4'(i)) begin
					if (wstrb_reg[1]) begin
						filter_reg[i].filter_standard_id[10:3] <= wdata_reg[15:8];
					end
					if (wstrb_reg[0]) begin
						filter_reg[i].filter_standard_id[2:0] <= wdata_reg[filter_sid_lsb +: 3];
						filter_reg[i].extended_id_enable <= wdata_reg[extended_enable_bit];
						filter_reg[i].eid_upper <= wdata_reg[extended_upper_lsb +: 2];
					end
				end
			end
		end
	end

	// Mode change waits the settle count before the status follows the request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			current_mode_reg <= op_mode_e'(current_mode_reset);
			settle_reg <= 3'h0;
		end else if (requested == current_mode_reg) begin
			settle_reg <= 3'h0;
		end else if (settle_reg == 3'(settle - 1)) begin
			current_mode_reg <= requested;
			settle_reg <= 3'h0;
		end else begin
			settle_reg <= settle_reg + 3'h1;
		end
	end

	filter_match #(
		.count(filters)
	) filter_match_inst (
		.header(rx_header),
		.filters(filter_reg),
		.mask_id_type_enable(mask_id_type_enable),
		.hit(hit_now)
	);

	// Registered match results; disabled and config modes give no hits or captures, but the last id is still taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filter_hit <= '0;
			rx_hit <= 1'b0;
			capture_event <= 1'b0;
			last_id_reg <= '0;
		end else begin
			if (current_mode_reg == mode_disabled || current_mode_reg == mode_config) begin
				filter_hit <= '0;
				rx_hit <= 1'b0;
				capture_event <= 1'b0;
			end else begin
				filter_hit <= hit_now;
				rx_hit <= |hit_now;
				capture_event <= rx_header.valid && receive_capture_enable_reg;
			end
			if (rx_header.valid) begin
				last_id_reg <= {rx_header.filter_standard_id, rx_header.extended, rx_header.eid_upper};
			end
		end
	end

	// Read mux; reserved bits read zero
	always_comb begin
		rdata_next = 32'h00000000;
		rd_err_next = 1'b0;
		if (s_axi_araddr == ctrl_one_off) begin
			rdata_next[mode_request_lsb +: 3] = mode_request_reg;
			rdata_next[current_mode_lsb +: 3] = current_mode_reg;
			rdata_next[capture_enable_bit] = receive_capture_enable_reg;
			rdata_next[window_select_bit] = window_reg;
		end else if (s_axi_araddr == status_off) begin
			rdata_next[filters-1:0] = filter_hit;
			rdata_next[16] = rx_hit;
		end else if (s_axi_araddr == rx_id_off) begin
			rdata_next[13:0] = last_id_reg;
		end else if (s_axi_araddr[7:6] == filter_base_off[7:6]) begin
			for (int i = 0; i < filters; i++) begin
				if (s_axi_araddr[5:2] == 4'(i)) begin
					rdata_next[15:5] = filter_reg[i].filter_standard_id;
					rdata_next[extended_enable_bit] = filter_reg[i].extended_id_enable;
					rdata_next[1:0] = filter_reg[i].eid_upper;
				end
			end
		end else begin
			rd_err_next = 1'b1;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rd_err_next ? resp_slverr : resp_okay; // Error taken with the data so both come from one address
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Status never shows a reserved code
	mode_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
		current_mode_reg != 3'h5 && current_mode_reg != 3'h6)
		else $error("reserved mode code reported");

	// Status follows a stable request within the settle time
	mode_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(requested != current_mode_reg) [*4] |=> current_mode_reg == $past(requested))
		else $error("mode status did not follow request");

	// Status never jumps without a pending request
	mode_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(current_mode_reg) |-> current_mode_reg == $past(requested))
		else $error("mode status changed without request");

	// Disable request code 1 decodes to the disabled mode
	request_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_request_reg == 3'h1 |-> requested == mode_disabled)
		else $error("disable request decoded wrongly");

	// Capture pulse only with the enable set and a message seen
	capture_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		capture_event |-> $past(receive_capture_enable_reg) && $past(rx_header.valid))
		else $error("capture without enable or message");

	// Enabled reception in normal mode gives a capture
	capture_fire_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_header.valid && receive_capture_enable_reg && current_mode_reg == mode_normal |=> capture_event)
		else $error("capture missed");

	// A hit needs an exact identifier match; filter three is the one software programs first
	hit_exact_a: assert property (@(posedge aclk) disable iff (!aresetn)
		filter_hit[3] |-> $past(rx_header.filter_standard_id) == $past(filter_reg[3].filter_standard_id))
		else $error("filter hit with mismatched identifier");

	// Filters are independent: writing one leaves another unchanged
	filter_indep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && awaddr_reg == filter_base_off + 8'h0c |=> $stable(filter_reg[4]))
		else $error("filter write leaked to neighbour");
endmodule

// [tb/can_node_model.sv]
// Purpose: Stand-in for the other CAN nodes, handing over received headers
// Assumes: One header pulse per send request, on aclk
// Notes: Between frames valid is low and the id lines flip to their own inverse every cycle, so a stale copy is never read as valid
`timescale 1ns/1ps
module can_node_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic send,
	input wire logic [10:0] filter_standard_id,
	output can_mode_pkg::rx_header_s rx_header
);
	import can_mode_pkg::*;
	// One-cycle header per requested standard frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_header <= '0;
		end else if (send) begin
			rx_header <= '{1'b1, 1'b0, filter_standard_id, 2'h0};
		end else begin
			rx_header <= '{1'b0, 1'b0, ~rx_header.filter_standard_id, 2'h3};
		end
	end
endmodule

// [tb/tb_can_mode_control.sv]
// Purpose: Self-checking bench for mode control and filter identifier registers
// Assumes: Settle count of 4, hit and capture outputs one cycle after a header
// Notes: Only standard frames are sent, type matching stays off
`timescale 1ns/1ps
module tb_can_mode_control;
	import can_mode_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, send;
	logic awready, wready, bvalid, arready, rvalid, window_select, capture_event, rx_hit;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdv;
	logic [1:0] bresp, rresp, rsp;
	logic [10:0] filter_standard_id;
	logic [15:0] filter_hit;
	rx_header_s rx_header;
	op_mode_e current_mode_status;
	int mismatches, checks;

	can_mode_control can_mode_control_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_header(rx_header), .mask_id_type_enable(1'b0),
		.current_mode_status(current_mode_status), .window_select(window_select),
		.capture_event(capture_event), .filter_hit(filter_hit), .rx_hit(rx_hit));
	can_node_model can_node_model_inst (.aclk(aclk), .aresetn(aresetn), .send(send),
		.filter_standard_id(filter_standard_id), .rx_header(rx_header));

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// A wait that ran out ends the run, since later steps would only pile up noise
	task automatic tmo(input int n);
		if (n >= 50) begin
			mismatches++;
			test_done();
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		rsp = bresp;
		// One idle edge, so a following call never re-raises bready in the step that lowered it
		@(posedge aclk);
		tmo(n);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		rready <= 1'b0;
		rdv = rdata;
		rsp = rresp;
		@(posedge aclk);
		tmo(n);
	endtask
	// One frame from the far side; outputs land one cycle after the header
	task automatic sendf(input logic [10:0] s, input logic [15:0] hit, input logic cap);
		filter_standard_id <= s;
		send <= 1'b1;
		@(posedge aclk);
		send <= 1'b0;
		// Header is up after the first edge, the hits after the second
		@(posedge aclk);
		#1;
		chk(filter_hit, hit);
		chk(rx_hit, |hit);
		chk(capture_event, cap);
		@(posedge aclk);
	endtask
	// Every request code except 4, reserved ones folding to configuration
	task automatic mode_walk;
		logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5, 3'h6, 3'h0};
		logic [2:0] prev, exp;
		int n;
		prev = 3'h4;
		foreach (codes[i]) begin
			exp = (codes[i] == 3'h5 || codes[i] == 3'h6) ? 3'h4 : codes[i];
			axi_wr(ctrl_one_off, {21'h0, codes[i], 8'h00});
			chk(rsp, resp_okay);
			chk(current_mode_status, prev);
			n = 0;
			while (current_mode_status !== exp && n < 10) begin
				@(posedge aclk);
				n++;
			end
			chk(current_mode_status, exp);
			axi_rd(ctrl_one_off);
			chk(rdv[7:5], exp);
			prev = exp;
		end
	endtask
	// Filter three holds 0x2a5; all others keep id zero so they stay silent
	task automatic filters_run;
		axi_wr(filter_base_off + 8'h0c, 32'h0000_54a0);
		axi_rd(filter_base_off + 8'h0c);
		chk(rdv, 32'h0000_54a0);
		axi_rd(filter_base_off + 8'h10);
		chk(rdv, 32'h0);
		axi_wr(ctrl_one_off, 32'h0000_0009);
		chk(window_select, 1'b1);
		sendf(11'h2a5, 16'h0008, 1'b1);
		for (int b = 0; b < 11; b++) begin
			sendf(11'h2a5 ^ (11'h1 << b), 16'h0, 1'b1);
		end
		axi_wr(ctrl_one_off, 32'h0);
		sendf(11'h2a5, 16'h0008, 1'b0);
		// Last header seen: standard id 0x2a5, type and upper bits zero
		axi_rd(rx_id_off);
		chk(rdv, 32'h0000_1528);
		axi_wr(status_off, 32'h1);
		chk(rsp, resp_slverr);
	endtask

	// Free-running clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// Main sequence
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		send = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		filter_standard_id = 11'h000;
		mismatches = 0;
		checks = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(ctrl_one_off);
		chk(rdv, 32'h0000_0480);
		mode_walk();
		filters_run();
		axi_rd(8'h30);
		chk(rsp, resp_slverr);
		chk(rdv, 32'h0);
		test_done();
	end
endmodule
